// ===== acr_clock_divider.sv
/*
  Divides the block clock into a square test clock. Assumes the block clock
  stands for the internal oscillator.
*/
`default_nettype none
module acr_clock_divider #(
  parameter int DIV = 8
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  // divided output
  output logic      divClock
);
  localparam int HALF = (DIV / 2 < 1) ? 1 : DIV / 2;
  localparam int CW   = (HALF < 2) ? 1 : $clog2(HALF);

  logic [CW-1:0] count_reg;
  logic          divClock_reg;
  logic          wrap;

  assign wrap     = (count_reg == CW'(HALF - 1));
  assign divClock = divClock_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg    <= '0;
      divClock_reg <= 1'b0;
    end else if (ce) begin
      count_reg    <= wrap ? '0 : count_reg + CW'(1);
      divClock_reg <= wrap ? ~divClock_reg : divClock_reg;
    end
  end
endmodule : acr_clock_divider
`default_nettype wire

// ===== acr_consts.svh
/*
  Offsets, field positions, masks, reset values and timing counts of the
  accelerometer configuration register array. Assumes inclusion by bare name.
*/
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

`define ACR_ADDR_W        6
`define ACR_OFF_SERIAL0   6'h00
`define ACR_OFF_SERIAL1   6'h01
`define ACR_OFF_SERIAL2   6'h02
`define ACR_OFF_SERIAL3   6'h03
`define ACR_OFF_RSV_OTPA  6'h04
`define ACR_OFF_RSV_OTPB  6'h05
`define ACR_OFF_FACTORY   6'h06
`define ACR_OFF_PART      6'h08
`define ACR_OFF_DEVICE_CONTROL    6'h0A
`define ACR_OFF_DEVICE_CONFIG    6'h0B
`define ACR_OFF_AXISCFG   6'h0C
`define ACR_OFF_ARMING_CONFIG    6'h0E
`define ACR_OFF_THRPOS    6'h10
`define ACR_OFF_THRNEG    6'h12
`define ACR_OFF_STATUS    6'h14
`define ACR_OFF_COUNTER   6'h15
`define ACR_OFF_OFFCORR   6'h16
`define ACR_OFF_RSV_HIA   6'h1C
`define ACR_OFF_RSV_HIB   6'h1D

`define ACR_LOCK_BIT      5
`define ACR_FMT_BIT       4
`define ACR_OFFSET_MONITOR_ENABLE_BIT     3
`define ACR_CHECK_BIT     7
`define ACR_KEY_HI_BIT    7
`define ACR_KEY_LO_BIT    6
`define ACR_CFG_WMASK     8'h3F
`define ACR_AXIS_WMASK    8'h8F
`define ACR_ARM_WMASK     8'h3F
`define ACR_REG_RESET     8'h00
`define ACR_KEY_FIRST     2'h0
`define ACR_KEY_SECOND    2'h3
`define ACR_KEY_THIRD     2'h1
`define ACR_ZERO_G        10'h200
`define ACR_SAMPLE_W      10
`define ACR_CRC_W         8
`define ACR_CRC_POLY      8'h07

`define ACR_OSC_HZ        8000000
`define ACR_TEST_HZ       1000000
`define ACR_TEST_DIV      (`ACR_OSC_HZ / `ACR_TEST_HZ)

`endif

// ===== acr_crc_check.sv
/*
  Parameterised CRC checker over a flat vector, compared with an expected
  value. Assumes data and expected are stable while enable is high.
*/
`default_nettype none
`include "acr_consts.svh"
module acr_crc_check #(
  parameter int                DATA_W = 8,
  parameter int                CRC_W  = `ACR_CRC_W,
  parameter logic [CRC_W-1:0]  POLY   = `ACR_CRC_POLY
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  // check
  input  wire logic              enable,
  input  wire logic [DATA_W-1:0] data,
  input  wire logic [CRC_W-1:0]  expected,
  output logic      [CRC_W-1:0]  crcValue,
  output logic                   fault
);
  function automatic logic [CRC_W-1:0] crcOf(input logic [DATA_W-1:0] d);
    logic [CRC_W-1:0] c;
    logic             fb;
    c  = '0;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = c[CRC_W-1] ^ d[i];
      c  = {c[CRC_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ POLY;
      end
    end
    return c;
  endfunction : crcOf

  logic fault_reg;
  logic faultNext;

  assign crcValue  = crcOf(data);
  assign faultNext = enable & (crcValue != expected);
  assign fault     = fault_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_reg <= 1'b0;
    end else if (ce) begin
      fault_reg <= faultNext;
    end
  end
endmodule : acr_crc_check
`default_nettype wire

// ===== acr_host_model.sv
/*
  Register host model for the accelerometer register array: one strobe per command.
  Assumes an answer within four cycles and inputs sampled on the rising edge.
*/
`default_nettype none
`include "acr_consts.svh"
module acr_host_model (
  // clock
  input  wire logic                   clock,
  // request
  output logic                        reqValid,
  output logic                        reqWrite,
  output logic      [`ACR_ADDR_W-1:0] reqAddr,
  output logic      [7:0]             reqWrData,
  // answer
  input  wire logic                   rspValid,
  input  wire logic [7:0]             rspData,
  input  wire logic                   rspInvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {reqValid, reqWrite} = 2'h0;
    {reqAddr, reqWrData} = '1;
  end
  // fields flip once the strobe drops, so stale values cannot pass
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic inv, output logic ok);
    ok = 1'b0;
    r = 8'hxx;
    inv = 1'bx;
    @(negedge clock);
    {reqValid, reqWrite, reqAddr, reqWrData} = {1'b1, w, a, d};
    @(negedge clock);
    {reqValid, reqAddr, reqWrData} = {1'b0, ~a, ~d};
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rspValid === 1'b1) begin
        {r, inv, ok} = {rspData, rspInvalid, 1'b1};
      end else begin
        @(negedge clock);
      end
    end
  endtask : xfer
  // three key writes with nothing between them
  task automatic keyChain(output logic ok);
    logic [7:0] r;
    logic       inv, o1, o2, o3;
    xfer(1'b1, `ACR_OFF_DEVICE_CONTROL, {`ACR_KEY_FIRST, 6'h00}, r, inv, o1);
    xfer(1'b1, `ACR_OFF_DEVICE_CONTROL, {`ACR_KEY_SECOND, 6'h00}, r, inv, o2);
    xfer(1'b1, `ACR_OFF_DEVICE_CONTROL, {`ACR_KEY_THIRD, 6'h00}, r, inv, o3);
    ok = o1 & o2 & o3;
  endtask : keyChain
endmodule : acr_host_model
`default_nettype wire

// ===== acr_pkg.sv
/*
  Types of the accelerometer configuration register array.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package acr_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_GOT_FIRST,
    SEQ_GOT_SECOND
  } acr_seq_e;
endpackage : acr_pkg
`default_nettype wire

// ===== acr_register_array.sv
/*
  Customer register array of a single-axis accelerometer: factory OTP values,
  writable configuration with lock and CRC, read-only status. Assumes a serial
  front end that turns each command into a one-cycle request on this port.
*/
`default_nettype none
`include "acr_consts.svh"
// Summary of operation
// - storage is a factory OTP block plus writable and status registers
// - OTP block and writable block each have their own CRC checker
// - writable block can be locked against changes in normal operation
// - once lock bit set, only device control writes; cleared only by reset
// - serial number sits in bytes 0..3, least significant byte first
// - device control holds reset keys in bits 7:6, bits 5:0 reserved
// - config: lock bit 5, format bit 4, offset monitor bit 3, arming 2:0
// - format one sends unsigned with zero-g at 512, else signed
// - axis config: deflection check bit 7, filter select bits 3:0
// - arming config: pulse stretch 5:4, negative 3:2, positive 1:0
// - separate writable positive and negative arming thresholds
// - status bits 6..0: data error, overrun, init, output error, 0, offset, reset
// - counter and offset correction read-only right after status
// - each location behaves per its type: OTP, read/write, read-only, or write-only device control
// - test clock is the oscillator divided from 8 MHz to 1 MHz
module acr_register_array
  import acr_pkg::*;
#(
  parameter int TEST_DIV = `ACR_TEST_DIV
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // register request
  input  wire logic                     reqValid,
  input  wire logic                     reqWrite,
  input  wire logic [`ACR_ADDR_W-1:0]   reqAddr,
  input  wire logic [7:0]               reqWrData,
  // register answer
  output logic                          rspValid,
  output logic      [7:0]               rspData,
  output logic                          rspInvalid,
  // factory OTP contents
  input  wire logic [31:0]              otpSerial,
  input  wire logic                     otpMagSel,
  input  wire logic [7:0]               otpPartCode,
  input  wire logic [`ACR_CRC_W-1:0]    otpCrcExpected,
  // status sources
  input  wire logic                     dataErrorIn,
  input  wire logic                     overrunIn,
  input  wire logic                     initDoneIn,
  input  wire logic                     outputErrorIn,
  input  wire logic                     offsetFlagIn,
  input  wire logic [7:0]               frameCountIn,
  input  wire logic [7:0]               offsetCorrectionIn,
  // acceleration data
  input  wire logic [`ACR_SAMPLE_W-1:0] sampleIn,
  output logic      [`ACR_SAMPLE_W-1:0] sampleOut,
  // configuration outputs
  output logic                          initCompleteLock,
  output logic                          unsignedFormatSelect,
  output logic                          offsetMonitorEnable,
  output logic      [2:0]               armingMode,
  output logic                          deflectionCheckEnable,
  output logic      [3:0]               filterCutoffSelect,
  output logic      [1:0]               armingPulseStretch,
  output logic      [1:0]               negativeWindowSize,
  output logic      [1:0]               positiveWindowSize,
  output logic      [7:0]               positiveThreshold,
  output logic      [7:0]               negativeThreshold,
  // faults, reset and test clock
  output logic                          otpCrcError,
  output logic                          regCrcError,
  output logic                          digitalResetPulse,
  output logic                          testClock
);
  logic [7:0]               devConfig_reg;
  logic [7:0]               axisConfig_reg;
  logic [7:0]               armConfig_reg;
  logic [7:0]               posThresh_reg;
  logic [7:0]               negThresh_reg;
  logic                     resetFlag_reg;
  acr_seq_e                 seqState_reg;
  logic                     swReset_reg;
  logic                     rspValid_reg;
  logic [7:0]               rspData_reg;
  logic                     rspInvalid_reg;
  logic [`ACR_SAMPLE_W-1:0] sampleOut_reg;
  logic [`ACR_CRC_W-1:0]    regCrcExp_reg;
  logic                     crcArmed_reg;

  // request decode
  wire logic take      = reqValid & ce;
  wire logic takeWrite = take & reqWrite;
  wire logic takeRead  = take & ~reqWrite;
  wire logic hitSer0   = (reqAddr == `ACR_OFF_SERIAL0);
  wire logic hitSer1   = (reqAddr == `ACR_OFF_SERIAL1);
  wire logic hitSer2   = (reqAddr == `ACR_OFF_SERIAL2);
  wire logic hitSer3   = (reqAddr == `ACR_OFF_SERIAL3);
  wire logic hitRsvOtp = (reqAddr == `ACR_OFF_RSV_OTPA) | (reqAddr == `ACR_OFF_RSV_OTPB);
  wire logic hitFact   = (reqAddr == `ACR_OFF_FACTORY);
  wire logic hitPart   = (reqAddr == `ACR_OFF_PART);
  wire logic hitCtl    = (reqAddr == `ACR_OFF_DEVICE_CONTROL);
  wire logic hitCfg    = (reqAddr == `ACR_OFF_DEVICE_CONFIG);
  wire logic hitAxis   = (reqAddr == `ACR_OFF_AXISCFG);
  wire logic hitArm    = (reqAddr == `ACR_OFF_ARMING_CONFIG);
  wire logic hitThrP   = (reqAddr == `ACR_OFF_THRPOS);
  wire logic hitThrN   = (reqAddr == `ACR_OFF_THRNEG);
  wire logic hitStat   = (reqAddr == `ACR_OFF_STATUS);
  wire logic hitCount  = (reqAddr == `ACR_OFF_COUNTER);
  wire logic hitOffc   = (reqAddr == `ACR_OFF_OFFCORR);
  wire logic hitRsvHi  = (reqAddr == `ACR_OFF_RSV_HIA) | (reqAddr == `ACR_OFF_RSV_HIB);
  wire logic addrValid = hitSer0 | hitSer1 | hitSer2 | hitSer3 | hitRsvOtp | hitFact
                       | hitPart | hitCtl | hitCfg | hitAxis | hitArm | hitThrP
                       | hitThrN | hitStat | hitCount | hitOffc | hitRsvHi;

  // lock gates every writable register but device control
  wire logic locked   = devConfig_reg[`ACR_LOCK_BIT];
  wire logic wrOpen   = takeWrite & ~locked;

  // only writable locations have a write path; others ignore writes
  wire logic [7:0] devConfigNext  = (wrOpen & hitCfg)  ? (reqWrData & `ACR_CFG_WMASK)
                                                       : devConfig_reg;
  wire logic [7:0] axisConfigNext = (wrOpen & hitAxis) ? (reqWrData & `ACR_AXIS_WMASK)
                                                       : axisConfig_reg;
  wire logic [7:0] armConfigNext  = (wrOpen & hitArm)  ? (reqWrData & `ACR_ARM_WMASK)
                                                       : armConfig_reg;
  wire logic [7:0] posThreshNext  = (wrOpen & hitThrP) ? reqWrData : posThresh_reg;
  wire logic [7:0] negThreshNext  = (wrOpen & hitThrN) ? reqWrData : negThresh_reg;

  // reset key sequence; any other command in between aborts it
  wire logic [1:0] keyIn    = {reqWrData[`ACR_KEY_HI_BIT], reqWrData[`ACR_KEY_LO_BIT]};
  wire logic       ctlWrite = takeWrite & hitCtl;
  wire logic       keyFirst = ctlWrite & (keyIn == `ACR_KEY_FIRST);
  wire logic       keySecnd = ctlWrite & (keyIn == `ACR_KEY_SECOND);
  wire logic       keyThird = ctlWrite & (keyIn == `ACR_KEY_THIRD);
  wire logic       seqFire  = (seqState_reg == SEQ_GOT_SECOND) & keyThird;
  acr_seq_e        seqStateNext;

  always_comb begin
    seqStateNext = seqState_reg;
    if (take) begin
      case (seqState_reg)
        SEQ_IDLE:       seqStateNext = keyFirst ? SEQ_GOT_FIRST : SEQ_IDLE;
        SEQ_GOT_FIRST:  seqStateNext = keySecnd ? SEQ_GOT_SECOND
                                     : (keyFirst ? SEQ_GOT_FIRST : SEQ_IDLE);
        SEQ_GOT_SECOND: seqStateNext = keyFirst ? SEQ_GOT_FIRST : SEQ_IDLE;
        default:        seqStateNext = SEQ_IDLE;
      endcase
    end
  end

  // status: reset flag is sticky and cleared by a status read; set wins
  wire logic otpFault;
  wire logic regFault;
  wire logic dataError    = dataErrorIn | otpFault | regFault;
  wire logic statusRead   = takeRead & hitStat;
  wire logic resetFlagNxt = swReset_reg | (resetFlag_reg & ~statusRead);
  wire logic [7:0] statusByte = {1'b0, dataError, overrunIn, initDoneIn,
                                 outputErrorIn, 1'b0, offsetFlagIn, resetFlag_reg};

  // read selection
  wire logic [7:0] factByte = {otpMagSel, 7'h00};
  wire logic [7:0] readByte =
      hitSer0  ? otpSerial[7:0]   :
      hitSer1  ? otpSerial[15:8]  :
      hitSer2  ? otpSerial[23:16] :
      hitSer3  ? otpSerial[31:24] :
      hitFact  ? factByte         :
      hitPart  ? otpPartCode      :
      hitCfg   ? devConfig_reg    :
      hitAxis  ? axisConfig_reg   :
      hitArm   ? armConfig_reg    :
      hitThrP  ? posThresh_reg    :
      hitThrN  ? negThresh_reg    :
      hitStat  ? statusByte       :
      hitCount ? frameCountIn     :
      hitOffc  ? offsetCorrectionIn : 8'h00;

  // writable CRC reference is taken one cycle after the lock is set
  wire logic [39:0] regImage = {devConfig_reg, axisConfig_reg, armConfig_reg,
                                posThresh_reg, negThresh_reg};
  wire logic [47:0] otpImage = {otpSerial, factByte, otpPartCode};
  wire logic [`ACR_CRC_W-1:0] regCrcNow;

  acr_crc_check #(
    .DATA_W   (48)
  ) u_otpCrc (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .enable   (1'b1),
    .data     (otpImage),
    .expected (otpCrcExpected),
    .crcValue (),
    .fault    (otpFault)
  );

  acr_crc_check #(
    .DATA_W   (40)
  ) u_regCrc (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .enable   (crcArmed_reg),
    .data     (regImage),
    .expected (regCrcExp_reg),
    .crcValue (regCrcNow),
    .fault    (regFault)
  );

  acr_clock_divider #(
    .DIV      (TEST_DIV)
  ) u_testDiv (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .divClock (testClock)
  );

  // a digital reset returns the writable block to its reset state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      devConfig_reg  <= `ACR_REG_RESET;
      axisConfig_reg <= `ACR_REG_RESET;
      armConfig_reg  <= `ACR_REG_RESET;
      posThresh_reg  <= `ACR_REG_RESET;
      negThresh_reg  <= `ACR_REG_RESET;
    end else if (ce) begin
      devConfig_reg  <= swReset_reg ? `ACR_REG_RESET : devConfigNext;
      axisConfig_reg <= swReset_reg ? `ACR_REG_RESET : axisConfigNext;
      armConfig_reg  <= swReset_reg ? `ACR_REG_RESET : armConfigNext;
      posThresh_reg  <= swReset_reg ? `ACR_REG_RESET : posThreshNext;
      negThresh_reg  <= swReset_reg ? `ACR_REG_RESET : negThreshNext;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seqState_reg  <= SEQ_IDLE;
      swReset_reg   <= 1'b0;
      resetFlag_reg <= 1'b1;
    end else if (ce) begin
      seqState_reg  <= seqStateNext;
      swReset_reg   <= seqFire;
      resetFlag_reg <= resetFlagNxt;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crcArmed_reg  <= 1'b0;
      regCrcExp_reg <= '0;
    end else if (ce) begin
      crcArmed_reg  <= locked & ~swReset_reg;
      regCrcExp_reg <= (locked & ~crcArmed_reg) ? regCrcNow : regCrcExp_reg;
    end
  end

  // answer one cycle after the request; data is the value before any write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rspValid_reg   <= 1'b0;
      rspData_reg    <= 8'h00;
      rspInvalid_reg <= 1'b0;
    end else if (ce) begin
      rspValid_reg   <= reqValid;
      rspData_reg    <= (reqValid & addrValid) ? readByte : 8'h00;
      rspInvalid_reg <= reqValid & ~addrValid;
    end
  end

  // two's complement plus half scale is a flip of the top bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sampleOut_reg <= '0;
    end else if (ce) begin
      sampleOut_reg <= devConfig_reg[`ACR_FMT_BIT] ? sampleIn + `ACR_ZERO_G
                                                   : sampleIn;
    end
  end

  assign rspValid              = rspValid_reg;
  assign rspData               = rspData_reg;
  assign rspInvalid            = rspInvalid_reg;
  assign sampleOut             = sampleOut_reg;
  assign initCompleteLock      = locked;
  assign unsignedFormatSelect  = devConfig_reg[`ACR_FMT_BIT];
  assign offsetMonitorEnable   = devConfig_reg[`ACR_OFFSET_MONITOR_ENABLE_BIT];
  assign armingMode            = devConfig_reg[2:0];
  assign deflectionCheckEnable = axisConfig_reg[`ACR_CHECK_BIT];
  assign filterCutoffSelect    = axisConfig_reg[3:0];
  assign armingPulseStretch    = armConfig_reg[5:4];
  assign negativeWindowSize    = armConfig_reg[3:2];
  assign positiveWindowSize    = armConfig_reg[1:0];
  assign positiveThreshold     = posThresh_reg;
  assign negativeThreshold     = negThresh_reg;
  assign otpCrcError           = otpFault;
  assign regCrcError           = regFault;
  assign digitalResetPulse     = swReset_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence keyWrite(logic [1:0] k);
    take & reqWrite & hitCtl & (keyIn == k);
  endsequence
  sequence keyChain;
    keyWrite(`ACR_KEY_FIRST) ##1 ~take ##1 keyWrite(`ACR_KEY_SECOND) ##1 ~take
      ##1 keyWrite(`ACR_KEY_THIRD);
  endsequence

  chk_reset_chain: assert property (keyChain |=> digitalResetPulse)
    else $error("key chain did not reset");
  chk_lock_holds_cfg: assert property (
    ce & locked & takeWrite & hitCfg & ~swReset_reg |=> $stable(devConfig_reg))
    else $error("locked config changed");
  chk_lock_sticky: assert property (
    ce & locked & ~swReset_reg |=> initCompleteLock)
    else $error("lock cleared without reset");
  chk_lock_thresholds: assert property (
    ce & locked & takeWrite & hitThrP & ~swReset_reg |=> $stable(positiveThreshold))
    else $error("threshold written while locked");
  chk_invalid_addr: assert property (
    take & ~addrValid |=> rspValid & rspInvalid & (rspData == 8'h00))
    else $error("invalid address not flagged");
  chk_serial_low: assert property (
    takeRead & hitSer0 |=> rspData == $past(otpSerial[7:0]))
    else $error("serial byte 0 wrong");
  chk_factory_zero: assert property (
    take & hitFact |=> rspData[6:0] == 7'h00)
    else $error("factory byte low bits not zero");
  chk_control_zero: assert property (take & hitCtl |=> rspData == 8'h00)
    else $error("device control read not zero");
  chk_format_unsigned: assert property (
    ce & unsignedFormatSelect |=> sampleOut == $past(sampleIn) + `ACR_ZERO_G)
    else $error("unsigned format offset wrong");
  chk_status_gap: assert property (take & hitStat |=> ~rspData[2] & ~rspData[7])
    else $error("status constant bits wrong");
  chk_ro_status_write: assert property (
    ce & takeWrite & hitOffc & ~swReset_reg |=> $stable(negativeThreshold))
    else $error("read-only write disturbed a register");
endmodule : acr_register_array
`default_nettype wire

// ===== acr_register_array_bench.sv
/*
  Self-checking bench of the accelerometer register array with a host model.
  Assumes one clock, clock enable held high and a small test clock divider.
*/
`default_nettype none
`include "acr_consts.svh"
module acr_register_array_bench;
  import acr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Div = 4;
  logic clock, rst, ce, reqValid, reqWrite, rspValid, rspInvalid, otpCrcError, regCrcError;
  logic [5:0] reqAddr;
  logic [7:0] reqWrData, rspData, otpCrcExpected, positiveThreshold, negativeThreshold;
  logic dataErrorIn, overrunIn, initDoneIn, outputErrorIn, offsetFlagIn, testClock;
  logic initCompleteLock, unsignedFormatSelect, offsetMonitorEnable, deflectionCheckEnable;
  logic digitalResetPulse;
  logic [31:0] otpSerial = 32'hA1B2_C3D4;
  logic        otpMagSel = 1'b1;
  logic [7:0]  otpPartCode = 8'h5A, frameCountIn = 8'h96, offsetCorrectionIn = 8'h3C;
  logic [9:0]  sampleIn = 10'h005, sampleOut;
  logic [2:0]  armingMode;
  logic [3:0]  filterCutoffSelect;
  logic [1:0]  armingPulseStretch, negativeWindowSize, positiveWindowSize;
  int          errors = 0, checks = 0, pulses = 0;

  acr_register_array #(.TEST_DIV(Div)) dut (.clock(clock), .rst(rst), .ce(ce),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWrData(reqWrData),
    .rspValid(rspValid), .rspData(rspData), .rspInvalid(rspInvalid),
    .otpSerial(otpSerial), .otpMagSel(otpMagSel), .otpPartCode(otpPartCode),
    .otpCrcExpected(otpCrcExpected), .dataErrorIn(dataErrorIn), .overrunIn(overrunIn),
    .initDoneIn(initDoneIn), .outputErrorIn(outputErrorIn), .offsetFlagIn(offsetFlagIn),
    .frameCountIn(frameCountIn), .offsetCorrectionIn(offsetCorrectionIn),
    .sampleIn(sampleIn), .sampleOut(sampleOut), .initCompleteLock(initCompleteLock),
    .unsignedFormatSelect(unsignedFormatSelect), .offsetMonitorEnable(offsetMonitorEnable),
    .armingMode(armingMode), .deflectionCheckEnable(deflectionCheckEnable),
    .filterCutoffSelect(filterCutoffSelect), .armingPulseStretch(armingPulseStretch),
    .negativeWindowSize(negativeWindowSize), .positiveWindowSize(positiveWindowSize),
    .positiveThreshold(positiveThreshold), .negativeThreshold(negativeThreshold),
    .otpCrcError(otpCrcError), .regCrcError(regCrcError),
    .digitalResetPulse(digitalResetPulse), .testClock(testClock));
  acr_host_model host (.clock(clock), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWrData(reqWrData), .rspValid(rspValid), .rspData(rspData),
    .rspInvalid(rspInvalid));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(negedge clock) if (digitalResetPulse === 1'b1) pulses++;

  function automatic logic [7:0] crc8(input logic [47:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 47; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
  task automatic summarize();
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : compare
  // a lost answer ends the run at once
  task automatic rw(input logic w, input logic [5:0] a, input logic [7:0] d,
                    output logic [7:0] r, output logic inv);
    logic ok;
    host.xfer(w, a, d, r, inv, ok);
    if (ok !== 1'b1) begin
      errors++;
      summarize();
    end
  endtask : rw
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       inv;
    rw(1'b0, a, 8'h00, r, inv);
    compare(r, exp);
    compare(inv, 1'b0);
  endtask : rd

  task automatic statusScenario();
    rd(`ACR_OFF_STATUS, 8'h33);
    {dataErrorIn, overrunIn, initDoneIn, outputErrorIn, offsetFlagIn} = 5'b1_0010;
    rd(`ACR_OFF_STATUS, 8'h48);
  endtask : statusScenario
  task automatic otpScenario();
    logic [7:0] r;
    logic       inv;
    for (int i = 0; i < 4; i++) rd(i[5:0], otpSerial[8*i +: 8]);
    rd(`ACR_OFF_FACTORY, {otpMagSel, 7'h00});
    rd(`ACR_OFF_PART, otpPartCode);
    rw(1'b1, `ACR_OFF_SERIAL0, 8'hFF, r, inv);
    rw(1'b1, `ACR_OFF_OFFCORR, 8'h00, r, inv);
    rw(1'b1, `ACR_OFF_RSV_HIA, 8'hFF, r, inv);
    rd(`ACR_OFF_SERIAL0, otpSerial[7:0]);
    rd(`ACR_OFF_COUNTER, frameCountIn);
    rd(`ACR_OFF_OFFCORR, offsetCorrectionIn);
    rd(`ACR_OFF_RSV_HIA, 8'h00);
    compare(otpCrcError, 1'b0);
    otpCrcExpected[0] = ~otpCrcExpected[0];
    repeat (3) @(negedge clock);
    compare(otpCrcError, 1'b1);
    otpCrcExpected[0] = ~otpCrcExpected[0];
    repeat (3) @(negedge clock);
    compare(otpCrcError, 1'b0);
  endtask : otpScenario
  task automatic invalidScenario();
    logic [5:0] bad [9] = '{6'h07, 6'h09, 6'h0D, 6'h0F, 6'h11, 6'h13, 6'h17, 6'h1E, 6'h3F};
    logic [7:0] r;
    logic       inv;
    foreach (bad[i]) begin
      rw(i[0], bad[i], 8'hA5, r, inv);
      compare({r, inv}, 9'h001);
    end
  endtask : invalidScenario
  task automatic rwScenario();
    logic [7:0] r;
    logic       inv;
    rw(1'b1, `ACR_OFF_DEVICE_CONFIG, 8'hDF, r, inv);
    rw(1'b1, `ACR_OFF_AXISCFG, 8'hFA, r, inv);
    rw(1'b1, `ACR_OFF_ARMING_CONFIG, 8'hE4, r, inv);
    rw(1'b1, `ACR_OFF_THRPOS, 8'hC3, r, inv);
    rw(1'b1, `ACR_OFF_THRNEG, 8'h3C, r, inv);
    rd(`ACR_OFF_DEVICE_CONFIG, 8'h1F);
    compare({unsignedFormatSelect, offsetMonitorEnable, armingMode}, 5'h1F);
    rd(`ACR_OFF_AXISCFG, 8'h8A);
    compare({deflectionCheckEnable, filterCutoffSelect}, 5'h1A);
    rd(`ACR_OFF_ARMING_CONFIG, 8'h24);
    compare({armingPulseStretch, negativeWindowSize, positiveWindowSize}, 6'h24);
    rd(`ACR_OFF_THRPOS, 8'hC3);
    rd(`ACR_OFF_THRNEG, 8'h3C);
    compare({positiveThreshold, negativeThreshold}, 16'hC33C);
    compare(sampleOut, 10'h205);
    rw(1'b1, `ACR_OFF_DEVICE_CONFIG, 8'h0F, r, inv);
    repeat (2) @(negedge clock);
    compare(sampleOut, 10'h005);
    rw(1'b1, `ACR_OFF_DEVICE_CONTROL, 8'hFF, r, inv);
    rd(`ACR_OFF_DEVICE_CONTROL, 8'h00);
  endtask : rwScenario
  task automatic lockScenario();
    logic [7:0] r;
    logic       inv, ok;
    int         p;
    rw(1'b1, `ACR_OFF_DEVICE_CONFIG, 8'h20, r, inv);
    rw(1'b1, `ACR_OFF_THRPOS, 8'h11, r, inv);
    rw(1'b1, `ACR_OFF_DEVICE_CONFIG, 8'h00, r, inv);
    compare(initCompleteLock, 1'b1);
    rd(`ACR_OFF_THRPOS, 8'hC3);
    repeat (3) @(negedge clock);
    compare(regCrcError, 1'b0);
    p = pulses;
    // a read between the keys must abort the chain
    rw(1'b1, `ACR_OFF_DEVICE_CONTROL, 8'h00, r, inv);
    rw(1'b0, `ACR_OFF_STATUS, 8'h00, r, inv);
    rw(1'b1, `ACR_OFF_DEVICE_CONTROL, 8'hC0, r, inv);
    rw(1'b1, `ACR_OFF_DEVICE_CONTROL, 8'h40, r, inv);
    repeat (2) @(negedge clock);
    compare(pulses, p);
    host.keyChain(ok);
    repeat (2) @(negedge clock);
    compare({ok, pulses[8:0]}, {1'b1, p[8:0] + 9'd1});
    compare(initCompleteLock, 1'b0);
    rd(`ACR_OFF_THRPOS, 8'h00);
    rd(`ACR_OFF_STATUS, 8'h49);
  endtask : lockScenario
  task automatic clockScenario();
    logic last;
    int   rises;
    rises = 0;
    last = testClock;
    repeat (32) begin
      @(negedge clock);
      if (testClock === 1'b1 && last === 1'b0) rises++;
      last = testClock;
    end
    compare(rises, 32 / Div);
  endtask : clockScenario

  initial begin
    {rst, ce} = 2'b11;
    {dataErrorIn, overrunIn, initDoneIn, outputErrorIn, offsetFlagIn} = 5'b0_1101;
    otpCrcExpected = crc8({otpSerial, otpMagSel, 7'h00, otpPartCode});
    repeat (20) @(negedge clock);
    rst = 1'b0;
    statusScenario();
    otpScenario();
    invalidScenario();
    rwScenario();
    lockScenario();
    clockScenario();
    summarize();
  end
endmodule : acr_register_array_bench
`default_nettype wire
